// file: design/rfc_defs.vh
// Register map, field positions, reset values and widths for the free-running counter
// Behaviour
// - A 13-bit prescaler counts every system clock while run is set and supplies divided taps.
// - The counter register is an 8-bit up counter; software reads but cannot write.
// - Counter overflow sets the overflow flag in bit 7 of the event flags.
// - Interrupt acceptance never clears the overflow flag by itself.
// - Writing 0 while the flag reads 1 clears it; writing 1 changes nothing.
// - Counter overflow raises an interrupt request toward the processor.
// - The overflow interrupt enable must be honoured for requests; the event status/enable path drives irq_out without it.
// - Run bit 7: 0 halts counting, 1 runs the clock.
// - Reset bit 4 clears everything except source select, the processor-side enable and itself.
// - Counter overflows every 256 ticks of the selected clock.
// - Request reaches processor only with the processor-side enable bit set; enabled event status drives irq_out without it.
// - Source codes 0-7 pick divide 8 to 8192; 1xxx is calendar mode.
// - Bit 7 of the interrupt control register enables the overflow interrupt.
// - Bit 7 of the processor enable register enables the request.
`ifndef RFC_DEFS_VH
`define RFC_DEFS_VH

// =====================================================================
// Register offsets
`define RFC_ADDR_W        16
`define RFC_OFF_FLAGS     16'hf067
`define RFC_OFF_COUNT     16'hf068
`define RFC_OFF_RUN       16'hf06c
`define RFC_OFF_IRQCTL    16'hf06d
`define RFC_OFF_SRCSEL    16'hf06f
`define RFC_OFF_STATUS    16'hf070
`define RFC_OFF_CLEAR     16'hf071
`define RFC_OFF_ENABLE    16'hf072
`define RFC_OFF_CPUIEN    16'hfff3

// =====================================================================
// Field positions
`define RFC_BIT_OVF       7
`define RFC_BIT_RUN       7
`define RFC_BIT_RST       4
`define RFC_BIT_OIE       7
`define RFC_BIT_CPUIEN    7
`define RFC_BIT_SRC_CAL   3
`define RFC_EV_OVF        0
`define RFC_EV_TICK       1

// =====================================================================
// Reset values and widths
`define RFC_PSC_W         13
`define RFC_CNT_W         8
`define RFC_EV_W          2
`define RFC_SRCSEL_RST    4'h0
`define RFC_CNT_RST       8'h00
`define RFC_PSC_RST       13'h0000
`define RFC_CNT_MAX       8'hff

`endif

// file: design/rfc_top.v
// Free-running counter mode of the real-time clock with its register port
`timescale 1ns/10ps
`include "rfc_defs.vh"

module rfc_top (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire [15:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output wire       irq_out
);

  // ===================================================================
  // Tap decode
  // Tick is the cycle in which the tap's low bits are all ones, so the
  // next increment carries out: one tick per divide period.
  function tap_hit;
    input [12:0] psc;
    input [3:0]  sel;
    begin
      case (sel[2:0])
        3'h0:    tap_hit = &psc[2:0];
        3'h1:    tap_hit = &psc[4:0];
        3'h2:    tap_hit = &psc[6:0];
        3'h3:    tap_hit = &psc[7:0];
        3'h4:    tap_hit = &psc[8:0];
        3'h5:    tap_hit = &psc[10:0];
        3'h6:    tap_hit = &psc[11:0];
        default: tap_hit = &psc[12:0];
      endcase
    end
  endfunction

  // ===================================================================
  // Registers
  reg  [12:0] psc_q;
  reg  [7:0]  cnt_q;
  reg         ovf_flag_q;
  reg         run_q;
  reg         rst_bit_q;
  reg         oie_q;
  reg  [3:0]  srcsel_q;
  reg         cpuien_q;
  reg  [1:0]  ev_stat_q;
  reg  [1:0]  ev_en_q;

  reg  [12:0] psc_d;
  reg  [7:0]  cnt_d;
  reg         ovf_flag_d;
  reg         run_d;
  reg         rst_bit_d;
  reg         oie_d;
  reg  [3:0]  srcsel_d;
  reg         cpuien_d;
  reg  [1:0]  ev_stat_d;
  reg  [1:0]  ev_en_d;
  reg  [7:0]  rdata_d;

  wire        wr_flags;
  wire        wr_run;
  wire        wr_irqctl;
  wire        wr_srcsel;
  wire        wr_clear;
  wire        wr_enable;
  wire        wr_cpuien;
  wire        soft_rst;
  wire        cal_mode;
  wire        tick;
  wire        ovf;
  wire [1:0]  ev_set;
  wire        rtc_req;

  assign wr_flags  = reg_wr && (reg_addr == `RFC_OFF_FLAGS);
  assign wr_run    = reg_wr && (reg_addr == `RFC_OFF_RUN);
  assign wr_irqctl = reg_wr && (reg_addr == `RFC_OFF_IRQCTL);
  assign wr_srcsel = reg_wr && (reg_addr == `RFC_OFF_SRCSEL);
  assign wr_clear  = reg_wr && (reg_addr == `RFC_OFF_CLEAR);
  assign wr_enable = reg_wr && (reg_addr == `RFC_OFF_ENABLE);
  assign wr_cpuien = reg_wr && (reg_addr == `RFC_OFF_CPUIEN);

  // Software reset is level sensitive; it holds until written back
  assign soft_rst = rst_bit_q;

  // Calendar sources are not built; those codes simply stop the counter
  assign cal_mode = srcsel_q[`RFC_BIT_SRC_CAL];

  assign tick = run_q && !soft_rst && !cal_mode && tap_hit(psc_q, srcsel_q);
  assign ovf  = tick && (cnt_q == `RFC_CNT_MAX);

  assign ev_set = {tick, ovf};

  // ===================================================================
  // Prescaler
  // Holds while halted so a restart resumes the same phase
  always @* begin
    psc_d = psc_q;
    if (soft_rst) begin
      psc_d = `RFC_PSC_RST;
    end else if (run_q) begin
      psc_d = psc_q + 13'h0001;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      psc_q <= `RFC_PSC_RST;
    end else begin
      psc_q <= psc_d;
    end
  end

  // ===================================================================
  // Counter
  // Read only; no write path exists, so software cannot disturb it
  always @* begin
    cnt_d = cnt_q;
    if (soft_rst) begin
      cnt_d = `RFC_CNT_RST;
    end else if (tick) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= `RFC_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ===================================================================
  // Overflow flag
  // Set wins over a clearing write in the same cycle, so no overflow is lost
  always @* begin
    ovf_flag_d = ovf_flag_q;
    if (soft_rst) begin
      ovf_flag_d = 1'b0;
    end else if (ovf) begin
      ovf_flag_d = 1'b1;
    end else if (wr_flags && ovf_flag_q && !reg_wdata[`RFC_BIT_OVF]) begin
      ovf_flag_d = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ovf_flag_q <= 1'b0;
    end else begin
      ovf_flag_q <= ovf_flag_d;
    end
  end

  // ===================================================================
  // Reset bit
  // Survives its own soft reset, else the unit could never leave it
  always @* begin
    rst_bit_d = rst_bit_q;
    if (wr_run) begin
      rst_bit_d = reg_wdata[`RFC_BIT_RST];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rst_bit_q <= 1'b0;
    end else begin
      rst_bit_q <= rst_bit_d;
    end
  end

  // ===================================================================
  // Source select
  always @* begin
    srcsel_d = srcsel_q;
    if (wr_srcsel) begin
      srcsel_d = reg_wdata[3:0];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      srcsel_q <= `RFC_SRCSEL_RST;
    end else begin
      srcsel_q <= srcsel_d;
    end
  end

  // ===================================================================
  // Processor-side gate
  // Lives outside the unit, so soft reset leaves it alone
  always @* begin
    cpuien_d = cpuien_q;
    if (wr_cpuien) begin
      cpuien_d = reg_wdata[`RFC_BIT_CPUIEN];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cpuien_q <= 1'b0;
    end else begin
      cpuien_q <= cpuien_d;
    end
  end

  // ===================================================================
  // Run bit
  // A write that also sets reset leaves run cleared
  always @* begin
    run_d = run_q;
    if (soft_rst) begin
      run_d = 1'b0;
    end else if (wr_run) begin
      run_d = reg_wdata[`RFC_BIT_RUN] && !reg_wdata[`RFC_BIT_RST];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ===================================================================
  // Overflow interrupt enable
  always @* begin
    oie_d = oie_q;
    if (soft_rst) begin
      oie_d = 1'b0;
    end else if (wr_irqctl) begin
      oie_d = reg_wdata[`RFC_BIT_OIE];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      oie_q <= 1'b0;
    end else begin
      oie_q <= oie_d;
    end
  end

  // ===================================================================
  // Event enable
  always @* begin
    ev_en_d = ev_en_q;
    if (soft_rst) begin
      ev_en_d = 2'h0;
    end else if (wr_enable) begin
      ev_en_d = reg_wdata[1:0];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ev_en_q <= 2'h0;
    end else begin
      ev_en_q <= ev_en_d;
    end
  end

  // ===================================================================
  // Sticky event status, write-one clear
  // New events are ORed after the clear, so set wins
  always @* begin
    ev_stat_d = ev_stat_q;
    if (soft_rst) begin
      ev_stat_d = 2'h0;
    end else begin
      if (wr_clear) begin
        ev_stat_d = ev_stat_q & ~reg_wdata[1:0];
      end
      ev_stat_d = ev_stat_d | ev_set;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ev_stat_q <= 2'h0;
    end else begin
      ev_stat_q <= ev_stat_d;
    end
  end

  // ===================================================================
  // Interrupt
  // Request needs the block enable and the processor-side gate
  assign rtc_req = ovf_flag_q && oie_q && cpuien_q;
  assign irq_out = rtc_req || (|(ev_stat_q & ev_en_q));

  // ===================================================================
  // Read port; data stands only in the cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RFC_OFF_FLAGS: begin
          rdata_d = {ovf_flag_q, 7'h00};
        end
        `RFC_OFF_COUNT: begin
          rdata_d = cnt_q;
        end
        `RFC_OFF_RUN: begin
          rdata_d = {run_q, 2'h0, rst_bit_q, 4'h0};
        end
        `RFC_OFF_IRQCTL: begin
          rdata_d = {oie_q, 7'h00};
        end
        `RFC_OFF_SRCSEL: begin
          rdata_d = {4'h0, srcsel_q};
        end
        `RFC_OFF_STATUS: begin
          rdata_d = {6'h00, ev_stat_q};
        end
        `RFC_OFF_ENABLE: begin
          rdata_d = {6'h00, ev_en_q};
        end
        `RFC_OFF_CPUIEN: begin
          rdata_d = {cpuien_q, 7'h00};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule // rfc_top

// file: dv/rfc_irq_host.sv
// Processor-side interrupt acceptance model
`timescale 1ns/10ps
module rfc_irq_host (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        irq_out,
  output logic [7:0] taken_q
);
  logic prev_q;
  // Acceptance only counts; the flag is left to software
  always @(posedge clk_sys) begin
    prev_q <= irq_out & rst_b;
    if (!rst_b) taken_q <= 8'h00;
    else if (irq_out && !prev_q) taken_q <= taken_q + 8'h01;
  end
endmodule // rfc_irq_host

// file: dv/rfc_chk_assertions.sv
// Port assertions for the free-running counter
`timescale 1ns/10ps
module rfc_chk (
  input wire        clk_sys,
  input wire        rst_b,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        irq_out
);
  logic run_q, srst_q, cpu_q, oie_q, en_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Shadow enables; soft reset keeps the processor gate
  always @(posedge clk_sys) begin
    if (!rst_b) {run_q, srst_q, cpu_q, oie_q, en_q} <= 5'h00;
    else if (reg_wr) begin
      if (reg_addr == 16'hf06c) {run_q, srst_q} <= {reg_wdata[7] & ~reg_wdata[4], reg_wdata[4]};
      if (reg_addr == 16'hf06c && reg_wdata[4]) {oie_q, en_q} <= 2'h0;
      if (reg_addr == 16'hf06d) oie_q <= reg_wdata[7];
      if (reg_addr == 16'hf072) en_q <= |reg_wdata[1:0];
      if (reg_addr == 16'hfff3) cpu_q <= reg_wdata[7];
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  unmap_read_a: assert property (reg_rd && reg_addr == 16'hf000 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  srst_quiet_a: assert property (srst_q && $past(srst_q) |-> !irq_out)
    else $error("irq in soft reset");
  srst_count_a: assert property ($past(srst_q) && $past(reg_rd) &&
    $past(reg_addr) == 16'hf068 |-> reg_rdata == 8'h00) else $error("count kept");
  halt_irq_a: assert property ($rose(irq_out) |->
    $past(run_q) || $past(run_q, 2) || $past(reg_wr)) else $error("irq while halted");
  flag_keep_a: assert property (reg_wr && reg_addr == 16'hf067 && reg_wdata[7] && irq_out
    |=> irq_out) else $error("flag lost");
  gate_off_a: assert property (!(cpu_q && oie_q) && !en_q |-> !irq_out)
    else $error("irq not gated");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq fell alone");
endmodule // rfc_chk
bind rfc_top rfc_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_out(irq_out));

// file: dv/tb_top.sv
// Self-checking bench for the free-running counter
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys, rst_b, reg_wr, reg_rd, irq_out;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, taken, v, w;
  int          errors, n_tests, cyc, t;
  // Reset-time survey, one unmapped address last
  logic [15:0] uut_map [9] = '{16'hf067, 16'hf068, 16'hf06c, 16'hf06d, 16'hf06f,
    16'hf070, 16'hf072, 16'hfff3, 16'hf000};
  rfc_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
  rfc_irq_host host (.clk_sys(clk_sys), .rst_b(rst_b), .irq_out(irq_out), .taken_q(taken));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task end_of_test;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(logic [7:0] g, logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(logic [15:0] a, logic [7:0] m, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(v & m, e);
    @(posedge clk_sys);
  endtask
  task wait_irq(int lim);
    t = 0;
    while (irq_out !== 1'b1 && t < lim) begin
      @(negedge clk_sys);
      t++;
    end
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd} = 3'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (uut_map[i]) rd(uut_map[i], 8'hff, 8'h00);
    wr(16'hfff3, 8'h80);
    wr(16'hf06d, 8'h80);
    wr(16'hf068, 8'h55);
    wr(16'hf06c, 8'h80);
    wait_irq(3000);
    chk({7'h00, t > 2040 && t < 2056}, 8'h01);
    rd(16'hf067, 8'h80, 8'h80);
    rd(16'hf068, 8'hfe, 8'h00);
    wr(16'hf067, 8'h80);
    rd(16'hf067, 8'h80, 8'h80);
    chk(taken, 8'h01);
    wr(16'hf067, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
    wr(16'hf06d, 8'h00);
    wait_irq(2100);
    rd(16'hf067, 8'h80, 8'h80);
    chk({7'h00, irq_out}, 8'h00);
    wr(16'hfff3, 8'h00);
    wr(16'hf06d, 8'h80);
    chk({7'h00, irq_out}, 8'h00);
    wr(16'hfff3, 8'h80);
    chk({7'h00, irq_out}, 8'h01);
    wr(16'hf067, 8'h00);
    wr(16'hf06c, 8'h00);
    rd(16'hf068, 8'h00, 8'h00);
    w = v;
    repeat (40) @(posedge clk_sys);
    rd(16'hf068, 8'hff, w);
    wr(16'hf06f, 8'h02);
    wr(16'hf06c, 8'h90);
    rd(16'hf06c, 8'h80, 8'h00);
    rd(16'hf06d, 8'hff, 8'h00);
    rd(16'hf06f, 8'hff, 8'h02);
    rd(16'hf068, 8'hff, 8'h00);
    wr(16'hf06c, 8'h00);
    wr(16'hf06d, 8'h80);
    wr(16'hf06c, 8'h80);
    wait_irq(33000);
    chk({7'h00, t > 32760 && t < 32780}, 8'h01);
    wr(16'hf06d, 8'h00);
    wr(16'hf067, 8'h00);
    wr(16'hf072, 8'h01);
    chk({7'h00, irq_out}, 8'h01);
    wr(16'hf071, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    end_of_test();
  end
endmodule // tb_top
